//--- psl_pkg.sv
// Package with constants, types and the register map of the reset, strap and indicator block
// Notes on behaviour
// - Forward the reference clock on its own output
// - Mode 1: link indicator shows link state only
// - Mode 2: lit on link, blinks on activity
// - Speed indicator lit at 100, unlit at 10
// - Reset is active low, held one microsecond
// - Reset returns every register but the pin synchroniser, strap capture and reset hold counter to its default
// - Reset discards and recaptures the strap settings
// - Straps are sampled while reset is active
// - Strap pins become outputs after reset release
package psl_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 4;             // Byte address width
	localparam int unsigned DATA_W = 32;            // Data width

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL  = 4'h0; // Control
	localparam logic [ADDR_W-1:0] OFF_STAT  = 4'h4; // Live status
	localparam logic [ADDR_W-1:0] OFF_STRAP = 4'h8; // Captured straps

	// Control fields and reset value
	localparam int unsigned CTRL_FWD_EN  = 0;       // Clock forward enable
	localparam int unsigned CTRL_OVR_EN  = 1;       // Indicator mode override enable
	localparam int unsigned CTRL_OVR_SEL = 2;       // Override mode, 1 = mode 2
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0001;

	// Status fields
	localparam int unsigned STAT_LINK  = 0;         // Link good
	localparam int unsigned STAT_SPEED = 1;         // 100 Mb/s
	localparam int unsigned STAT_ACT   = 2;         // Activity pending
	localparam int unsigned STAT_MODE  = 3;         // Mode in use, 1 = mode 2
	localparam int unsigned STAT_PHASE = 4;         // Blink phase, 1 = lit
	localparam int unsigned STAT_RSTOK = 5;         // Last reset long enough

	// Shared strap pin positions
	localparam int unsigned NPINS    = 3;           // Shared pins
	localparam int unsigned PIN_LINK = 0;           // Link indicator pin
	localparam int unsigned PIN_SPD  = 1;           // Speed indicator pin
	localparam int unsigned PIN_CFG  = 2;           // Carrier sense / indicator config
	localparam logic [NPINS-1:0] STRAP_RST = 3'h7;  // Pull-up defaults

	// Indicator levels
	localparam logic LED_LIT   = 1'b1;              // Lit level
	localparam logic LED_UNLIT = 1'b0;              // Unlit level

	// Timing
	localparam int unsigned CLK_MHZ       = 40;     // ref_clk_i rate
	localparam int unsigned RST_MIN_NS    = 1000;   // Least reset hold
	localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_CNT_W     = 8;      // Reset hold counter width
	localparam int unsigned BLINK_HALF_MS = 50;     // Blink half period
	localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

	// Indicator modes
	typedef enum logic {
		PSL_MODE1 = 1'b0,                           // Link only
		PSL_MODE2 = 1'b1                            // Link and activity
	} psl_mode_t;

	// Transceiver status bundle
	typedef struct packed {
		logic link_good;                            // Link is good
		logic speed_100;                            // 100 Mb/s
		logic tx_active;                            // Transmit path active
		logic rx_active;                            // Receive path active
		logic carrier;                              // Carrier sense
	} psl_phy_stat_t;

	// Avalon request bundle
	typedef struct packed {
		logic              read;                    // Read strobe
		logic              write;                   // Write strobe
		logic [ADDR_W-1:0] address;                 // Byte address
		logic [DATA_W-1:0] writedata;               // Write data
	} psl_av_req_t;

endpackage : psl_pkg

//--- psl_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psl_sync #(
	parameter int unsigned W = 1                    // Bits to synchronise
) (
	// Clock
	input  wire logic         ref_clk_i,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;                           // First stage, read only by second

	// Per bit two stage chain
	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge ref_clk_i) begin
			meta_q[b] <= async_i[b];
			sync_o[b] <= meta_q[b];
		end
	end

endmodule : psl_sync

//--- psl_top.sv
// Reset, strap capture, clock forwarding and indicator logic with Avalon-MM registers
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module psl_top #(
	parameter int unsigned BLINK_HALF_CYC = psl_pkg::BLINK_HALF_CYC  // Blink half period
) (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_n_i,
	// Reference clock pins
	input  wire logic                          ref_clock_input_i,
	output logic                               crystal_drive_output_o,
	output logic                               ref_clock_forward_output_o,
	// Shared strap / indicator pins
	input  wire logic [psl_pkg::NPINS-1:0]     pin_i,
	output logic      [psl_pkg::NPINS-1:0]     pin_o,
	output logic      [psl_pkg::NPINS-1:0]     pin_oe_n_o,
	// Transceiver status
	input  wire psl_pkg::psl_phy_stat_t        phy_stat_i,
	// Avalon-MM slave
	input  wire logic                          avs_read_i,
	input  wire logic                          avs_write_i,
	input  wire logic [psl_pkg::ADDR_W-1:0]    avs_address_i,
	input  wire logic [psl_pkg::DATA_W-1:0]    avs_writedata_i,
	output logic      [psl_pkg::DATA_W-1:0]    avs_readdata_o,
	output logic                               avs_waitrequest_o
);

	localparam int unsigned CW = $clog2(BLINK_HALF_CYC);           // Blink counter width
	localparam logic [CW-1:0] BLINK_LAST = CW'(BLINK_HALF_CYC - 1); // Last count

	psl_pkg::psl_av_req_t       req;                // Bundled bus request
	logic [psl_pkg::NPINS:0]    sync_s;             // Synchronised pins and reference
	logic [psl_pkg::NPINS-1:0]  pin_s;              // Synchronised shared pins
	logic                       ref_s;              // Synchronised reference clock
	logic [psl_pkg::DATA_W-1:0] ctrl_q;             // Control register
	logic [psl_pkg::NPINS-1:0]  strap_q;            // Captured straps
	logic                       wait_q;             // Waitrequest flop
	logic [psl_pkg::DATA_W-1:0] rdata_q;            // Read data flop
	logic [psl_pkg::DATA_W-1:0] rdata_d;            // Read data mux
	logic [psl_pkg::DATA_W-1:0] stat_w;             // Status word
	logic                       rst_prev_q;         // Reset level one cycle ago
	logic [psl_pkg::RST_CNT_W-1:0] rst_cnt_q;       // Reset low cycle count
	logic [CW-1:0]              blink_cnt_q;        // Blink period counter
	logic                       tick;               // End of blink half period
	logic                       act_pend_q;         // Activity seen this half period
	logic                       phase_q;            // Blink phase, 1 = lit
	logic                       fwd_q;              // Forwarded clock flop
	logic                       xtal_q;             // Crystal drive flop
	logic [psl_pkg::NPINS-1:0]  pin_q;              // Pin output flops
	logic [psl_pkg::NPINS-1:0]  oe_n_q;             // Pin enable flops
	logic                       link_led_d;         // Next link indicator level
	psl_pkg::psl_mode_t         mode;               // Indicator mode in use
	logic                       bus_hit;            // Request taken this edge

	assign req = '{read: avs_read_i, write: avs_write_i,
	               address: avs_address_i, writedata: avs_writedata_i};

	// Pins and reference clock come from outside the clock domain
	psl_sync #(
		.W (psl_pkg::NPINS + 1)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.async_i   ({ref_clock_input_i, pin_i}),
		.sync_o    (sync_s)
	);
	assign pin_s = sync_s[psl_pkg::NPINS-1:0];
	assign ref_s = sync_s[psl_pkg::NPINS];

	// Reset hold counter, restarts at the first low cycle and saturates
	always_ff @(posedge ref_clk_i) begin
		rst_prev_q <= rst_n_i;
		if (!rst_n_i) begin
			if (rst_prev_q) begin
				rst_cnt_q <= psl_pkg::RST_CNT_W'(1);
			end else if (rst_cnt_q != '1) begin
				rst_cnt_q <= rst_cnt_q + psl_pkg::RST_CNT_W'(1);
			end
		end
	end

	// Strap capture follows the pins all through reset, frozen after it
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			strap_q <= pin_s;
		end
	end

	// Indicator mode: strap unless software overrides it
	always_comb begin
		if (ctrl_q[psl_pkg::CTRL_OVR_EN]) begin
			mode = psl_pkg::psl_mode_t'(ctrl_q[psl_pkg::CTRL_OVR_SEL]);
		end else if (strap_q[psl_pkg::PIN_CFG]) begin
			mode = psl_pkg::PSL_MODE1;
		end else begin
			mode = psl_pkg::PSL_MODE2;
		end
	end

	// Free running blink half period counter
	assign tick = (blink_cnt_q == BLINK_LAST);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			blink_cnt_q <= '0;
		end else if (tick) begin
			blink_cnt_q <= '0;
		end else begin
			blink_cnt_q <= blink_cnt_q + CW'(1);
		end
	end

	// Activity pending flag, a new event wins over the clear at tick
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			act_pend_q <= 1'b0;
		end else if (phy_stat_i.tx_active || phy_stat_i.rx_active) begin
			act_pend_q <= 1'b1;
		end else if (tick) begin
			act_pend_q <= 1'b0;
		end
	end

	// Blink phase toggles while active, settles lit when idle
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			phase_q <= 1'b1;
		end else if (tick) begin
			if (act_pend_q) begin
				phase_q <= ~phase_q;
			end else begin
				phase_q <= 1'b1;
			end
		end
	end

	// Link indicator level per mode
	always_comb begin
		link_led_d = psl_pkg::LED_UNLIT;
		unique case (mode)
			psl_pkg::PSL_MODE1: begin
				if (phy_stat_i.link_good) begin
					link_led_d = psl_pkg::LED_LIT;
				end
			end
			psl_pkg::PSL_MODE2: begin
				if (phy_stat_i.link_good && phase_q) begin
					link_led_d = psl_pkg::LED_LIT;
				end
			end
		endcase
	end

	// Shared pins: released during reset so straps can be read, driven after
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pin_q  <= '0;
			oe_n_q <= '1;
		end else begin
			oe_n_q <= '0;
			pin_q[psl_pkg::PIN_LINK] <= link_led_d;
			pin_q[psl_pkg::PIN_SPD]  <= phy_stat_i.speed_100 ?
			                            psl_pkg::LED_LIT : psl_pkg::LED_UNLIT;
			pin_q[psl_pkg::PIN_CFG]  <= phy_stat_i.carrier;
		end
	end

	// Reference forwarding, sampled copy of the reference pin
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			fwd_q  <= 1'b0;
			xtal_q <= 1'b0;
		end else begin
			fwd_q  <= ref_s & ctrl_q[psl_pkg::CTRL_FWD_EN];
			xtal_q <= ~ref_s;
		end
	end

	// Status word seen by software
	always_comb begin
		stat_w = '0;
		stat_w[psl_pkg::STAT_LINK]  = phy_stat_i.link_good;
		stat_w[psl_pkg::STAT_SPEED] = phy_stat_i.speed_100;
		stat_w[psl_pkg::STAT_ACT]   = act_pend_q;
		stat_w[psl_pkg::STAT_MODE]  = (mode == psl_pkg::PSL_MODE2);
		stat_w[psl_pkg::STAT_PHASE] = phase_q;
		stat_w[psl_pkg::STAT_RSTOK] = (rst_cnt_q >= psl_pkg::RST_CNT_W'(psl_pkg::RST_MIN_CYC));
	end

	// Read mux, unmapped offsets read zero
	always_comb begin
		rdata_d = '0;
		unique case (req.address)
			psl_pkg::OFF_CTRL:  rdata_d = ctrl_q;
			psl_pkg::OFF_STAT:  rdata_d = stat_w;
			psl_pkg::OFF_STRAP: rdata_d = {{(psl_pkg::DATA_W-psl_pkg::NPINS){1'b0}}, strap_q};
			default:            rdata_d = '0;
		endcase
	end

	// One wait cycle per access, then the request is taken
	assign bus_hit = (req.read || req.write) && !wait_q;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wait_q  <= 1'b1;
			rdata_q <= '0;
		end else begin
			if ((req.read || req.write) && wait_q) begin
				wait_q  <= 1'b0;
				rdata_q <= rdata_d;
			end else begin
				wait_q  <= 1'b1;
			end
		end
	end

	// Control register write, only writable bits kept
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= psl_pkg::CTRL_RST;
		end else if (bus_hit && req.write && req.address == psl_pkg::OFF_CTRL) begin
			ctrl_q <= req.writedata & 32'h0000_0007;
		end
	end

	// Outputs straight from flops
	assign ref_clock_forward_output_o = fwd_q;
	assign crystal_drive_output_o     = xtal_q;
	assign pin_o                      = pin_q;
	assign pin_oe_n_o                 = oe_n_q;
	assign avs_readdata_o             = rdata_q;
	assign avs_waitrequest_o          = wait_q;

endmodule : psl_top

//--- psl_props.sv
// Port-level assertions for the reset, strap and indicator block
`timescale 1ns/1ps
module psl_props #(
	parameter int unsigned BLINK_HALF_CYC = psl_pkg::BLINK_HALF_CYC // Blink half period
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	// Clock pins
	input  wire logic                         crystal_drive_output_o,
	input  wire logic                         ref_clock_forward_output_o,
	// Indicator pins and status
	input  wire logic [psl_pkg::NPINS-1:0]    pin_o,
	input  wire logic [psl_pkg::NPINS-1:0]    pin_oe_n_o,
	input  wire psl_pkg::psl_phy_stat_t       phy_stat_i,
	// Register bus
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [psl_pkg::DATA_W-1:0]   avs_readdata_o,
	input  wire logic                         avs_waitrequest_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	int unsigned idle_q;                          // Cycles of link without traffic

	// Count steady link with no traffic, saturating
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !phy_stat_i.link_good || phy_stat_i.tx_active || phy_stat_i.rx_active) begin
			idle_q <= 0;
		end else if (idle_q < 1000) begin
			idle_q <= idle_q + 1;
		end
	end

	a_reset_pins: assert property (disable iff (1'b0)
		!rst_n_i |=> pin_oe_n_o == 3'h7 && pin_o == 3'h0) else $error("pins driven in reset");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
		!ref_clock_forward_output_o && !crystal_drive_output_o && avs_waitrequest_o
		&& avs_readdata_o == 32'h0000_0000)
		else $error("outputs not at default in reset");
	a_pins_taken: assert property (rst_n_i |=> pin_oe_n_o == 3'h0)
		else $error("pins not driven after reset");
	a_speed_follow: assert property (rst_n_i |=> pin_o[1] == $past(phy_stat_i.speed_100))
		else $error("speed indicator wrong");
	a_link_gate: assert property (rst_n_i && !phy_stat_i.link_good |=> pin_o[0] == 1'b0)
		else $error("link indicator lit without link");
	a_idle_lit: assert property (idle_q > 2 * BLINK_HALF_CYC + 3 |-> pin_o[0] == 1'b1)
		else $error("link indicator not steady when idle");
	a_fwd_excl: assert property (ref_clock_forward_output_o |-> !crystal_drive_output_o)
		else $error("forwarded clock disagrees with reference");
	a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer one cycle after request");
	a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer stands more than one cycle");
endmodule : psl_props

bind psl_top psl_props #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) props_u (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .crystal_drive_output_o(crystal_drive_output_o),
	.ref_clock_forward_output_o(ref_clock_forward_output_o), .pin_o(pin_o),
	.pin_oe_n_o(pin_oe_n_o), .phy_stat_i(phy_stat_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o));

//--- psl_board.sv
// Board model: reference oscillator and strap resistors on shared pins
`timescale 1ns/1ps
module psl_board (
	// Strap resistor levels and device drive
	input  wire logic [psl_pkg::NPINS-1:0] strap_i,
	input  wire logic [psl_pkg::NPINS-1:0] pin_o_i,
	input  wire logic [psl_pkg::NPINS-1:0] pin_oe_n_i,
	// Oscillator and pin levels
	output logic                            osc_o,
	output logic [psl_pkg::NPINS-1:0]      pin_lvl_o
);
	// 25 MHz oscillator, 50 ppm slow, free running
	initial begin
		osc_o = 1'b0;
		forever #20.001 osc_o = ~osc_o;
	end

	// Released pins fall to the weak strap resistor level
	always_comb begin
		for (int b = 0; b < psl_pkg::NPINS; b++) begin
			pin_lvl_o[b] = pin_oe_n_i[b] ? strap_i[b] : pin_o_i[b];
		end
	end
endmodule : psl_board

//--- testbench.sv
// Self-checking bench for the reset, strap and indicator block
`timescale 1ns/1ps
module testbench;
	localparam int unsigned HALF = 8;                 // Short blink half period
	logic                       ref_clk_i = 1'b0;    // 40 MHz clock
	logic                       rst_n_i = 1'b0;      // Reset, active low
	logic                       osc, wreq, xtal, fwd; // Board and device outputs
	logic [2:0]                 strap = 3'h7;        // Strap resistor levels
	logic [2:0]                 pin_lvl, pin_o, pin_oe_n;
	psl_pkg::psl_phy_stat_t     stat = '0;           // Transceiver status
	logic                       rd = 1'b0, wr = 1'b0;
	logic [3:0]                 addr = '0;
	logic [31:0]                wdata = '0, rdata;
	logic [63:0]                rq[$];               // Read notes: mask, value
	logic [2:0]                 lq[$];               // Indicator notes
	int                         mismatches = 0, n_checks = 0;
	int                         on, flips, xflips = 0;
	logic                       xtal_p = 1'b0;       // Last crystal drive level

	always #12.5 ref_clk_i = ~ref_clk_i;

	psl_board board_u (.strap_i(strap), .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n), .osc_o(osc),
		.pin_lvl_o(pin_lvl));
	psl_top #(.BLINK_HALF_CYC(HALF)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.ref_clock_input_i(osc), .crystal_drive_output_o(xtal),
		.ref_clock_forward_output_o(fwd), .pin_i(pin_lvl), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n), .phy_stat_i(stat), .avs_read_i(rd), .avs_write_i(wr),
		.avs_address_i(addr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq));

	// Print the verdict and stop
	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	// One comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	// One bus access; a read notes its expected value
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, m);
		int k;
		@(posedge ref_clk_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		if (!w) rq.push_back({m, d & m});
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk_i);
			if (wreq === 1'b0) break;
		end
		if (k == 20) begin
			mismatches++;
			give_verdict();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// Reset held for n edges with new strap levels
	task automatic do_reset(input int n, input logic [2:0] s);
		@(posedge ref_clk_i);
		strap <= s;
		rst_n_i <= 1'b0;
		repeat (n) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
	endtask : do_reset

	// Count lit link samples and forwarded clock changes
	task automatic watch(input int n, output int o, output int f);
		logic p;
		o = 0;
		f = 0;
		p = fwd;
		repeat (n) begin
			@(negedge ref_clk_i);
			o += (pin_o[0] === 1'b1);
			f += (fwd !== p);
			p = fwd;
		end
	endtask : watch

	// Read answers against the oldest note
	always @(posedge ref_clk_i) begin
		if (rst_n_i && rd && wreq === 1'b0 && rq.size() > 0) begin
			chk("readdata", rq[0][31:0], rdata & rq[0][63:32]);
			void'(rq.pop_front());
		end
	end

	// Indicator outputs against the oldest note
	always @(negedge ref_clk_i) begin
		if (lq.size() > 0) chk("indicators", 32'(lq.pop_front()), 32'(pin_o));
	end

	// Count crystal drive changes over the whole run
	always @(negedge ref_clk_i) begin
		if (xtal !== xtal_p) xflips++;
		xtal_p = xtal;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		give_verdict();
	end

	// Main sequence
	initial begin
		logic [2:0] s;
		void'($urandom(32'hf607278d));
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		bus(0, psl_pkg::OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
		for (int i = 0; i < 2; i++) begin
			bus(1, psl_pkg::OFF_CTRL, 32'hFFFF_FFFF, '0);
			bus(0, psl_pkg::OFF_CTRL, 32'h0000_0007, 32'hFFFF_FFFF);
			s = {i[0], 2'($urandom)};
			do_reset(39 + i, s);
			bus(1, psl_pkg::OFF_STRAP, 32'h0000_0000, '0);
			bus(0, psl_pkg::OFF_STRAP, 32'(s), 32'h0000_0007);
			bus(0, psl_pkg::OFF_STAT, 32'(i * 32 + (1 - i) * 8), 32'h0000_0028);
			bus(0, psl_pkg::OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
		end
		bus(0, 4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
		// Random status in link-only mode
		for (int k = 0; k < 40; k++) begin
			@(posedge ref_clk_i);
			if (k > 0) lq.push_back({stat.carrier, stat.speed_100, stat.link_good});
			stat <= 5'($urandom);
		end
		watch(100, on, flips);
		chk("fwd_flips", 32'h0000_0001, 32'(flips > 20));
		// Activity blink under override
		@(posedge ref_clk_i);
		stat <= 5'h14;
		bus(1, psl_pkg::OFF_CTRL, 32'h0000_0006, '0);
		watch(4 * HALF, on, flips);
		watch(6 * HALF, on, flips);
		chk("blink_on", 32'(3 * HALF), 32'(on));
		chk("fwd_off", 32'h0000_0000, 32'(flips));
		bus(0, psl_pkg::OFF_STAT, 32'h0000_002D, 32'h0000_002F);
		@(posedge ref_clk_i);
		stat <= 5'h10;
		watch(3 * HALF, on, flips);
		watch(2 * HALF, on, flips);
		chk("idle_lit", 32'(2 * HALF), 32'(on));
		bus(0, psl_pkg::OFF_STAT, 32'h0000_0039, 32'h0000_003F);
		@(posedge ref_clk_i);
		stat <= 5'h14;
		bus(1, psl_pkg::OFF_CTRL, 32'h0000_0002, '0);
		watch(2, on, flips);
		watch(4 * HALF, on, flips);
		chk("mode1_lit", 32'(4 * HALF), 32'(on));
		chk("xtal_flips", 32'h0000_0001, 32'(xflips > 100));
		give_verdict();
	end
endmodule : testbench
